// >>> common/ssd_defs.svh
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSD_ADDR_W          6
`define SSD_OFS_STATUS      6'h0E
`define SSD_OFS_TEST_CFG    6'h0F
`define SSD_OFS_OSC_MON     6'h10

// ****************************************
// System status field positions
// ****************************************
`define SSD_SYS_ALERT_LEVEL 15
`define SSD_SYS_ALERT_FAULT 14
`define SSD_SYS_SO_FAULT    13
`define SSD_SYS_CRC         12
`define SSD_SYS_FRAME       11
`define SSD_SYS_OPST_HI     10
`define SSD_SYS_OPST_LO     8
`define SSD_SYS_OV          5
`define SSD_SYS_UV          4
`define SSD_SYS_TEMP        3
`define SSD_SYS_ZTH         2
`define SSD_SYS_YTH         1
`define SSD_SYS_XTH         0
`define SSD_SYS_FLAG_MASK   16'h783F
`define SSD_SYS_RESET       16'h0000

// ****************************************
// Test configuration field positions
// ****************************************
`define SSD_TC_RSVD_HI      15
`define SSD_TC_RSVD_LO      6
`define SSD_TC_RSVD_VAL     10'h001
`define SSD_TC_REV_HI       5
`define SSD_TC_REV_LO       4
`define SSD_TC_CKSUM        2
`define SSD_TC_OSC_HI       1
`define SSD_TC_OSC_LO       0
`define SSD_OSC_MON_RESET   16'h0000

// ****************************************
// Timing
// ****************************************
`define SSD_CLK_PERIOD_PS   8000
`define SSD_ALERT_SETTLE_NS 40
`define SSD_ALERT_SETTLE_CYC \
  ((`SSD_ALERT_SETTLE_NS * 1000 + `SSD_CLK_PERIOD_PS - 1) / `SSD_CLK_PERIOD_PS)

`endif

// >>> common/ssd_pkg.sv
package ssd_pkg;

  typedef enum logic [1:0] {
    SSD_OSC_RESET,
    SSD_OSC_FAST,
    SSD_OSC_SLOW,
    SSD_OSC_STOP
  } ssd_osc_ctl_t;

  typedef enum logic [2:0] {
    SSD_ST_CONFIG,
    SSD_ST_STANDBY,
    SSD_ST_ACTIVE_CONT,
    SSD_ST_ACTIVE_TRIG,
    SSD_ST_DUTY_ACTIVE,
    SSD_ST_DUTY_SLEEP,
    SSD_ST_SLEEP
  } ssd_opstate_t;

endpackage

// >>> src/ssd_osc_counter.sv
`timescale 1ns/1ps
`include "ssd_defs.svh"

module ssd_osc_counter
  import ssd_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             fast_osc_clk_in,
  input  wire logic             nrst_in,
  input  wire logic [1:0]       ctl_in,
  input  wire logic             slow_osc_in,
  output logic      [CNT_W-1:0] count_gray_out
);

  initial begin
    if (CNT_W < 2) $error("CNT_W must be at least 2");
  end

  // ****************************************
  // Crossings into the oscillator domain
  // ****************************************
  logic [1:0]       rst_sync_q;
  logic [1:0]       ctl_s1_q;
  logic [1:0]       ctl_s2_q;
  logic [1:0]       ctl_s3_q;
  logic [2:0]       slow_sync_q;
  logic             rst_n;
  ssd_osc_ctl_t     ctl_q;
  ssd_osc_ctl_t     ctl_prev_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             slow_rise;

  always_ff @(posedge fast_osc_clk_in) begin
    rst_sync_q <= {rst_sync_q[0], nrst_in};
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge fast_osc_clk_in) begin
    ctl_s1_q <= ctl_in;
    ctl_s2_q <= ctl_s1_q;
    ctl_s3_q <= ctl_s2_q;
  end

  // Control is taken only after two equal samples, so a skewed bit is never seen.
  always_ff @(posedge fast_osc_clk_in) begin
    if (!rst_n) begin
      ctl_q      <= SSD_OSC_RESET;
      ctl_prev_q <= SSD_OSC_RESET;
    end else begin
      if (ctl_s2_q == ctl_s3_q) ctl_q <= ssd_osc_ctl_t'(ctl_s3_q);
      ctl_prev_q <= ctl_q;
    end
  end

  always_ff @(posedge fast_osc_clk_in) begin
    slow_sync_q <= {slow_sync_q[1:0], slow_osc_in};
  end
  assign slow_rise = slow_sync_q[1] & ~slow_sync_q[2];

  // ****************************************
  // Counter
  // ****************************************
  always_comb begin
    count_d = count_q;
    case (ctl_q)
      SSD_OSC_RESET: count_d = '0;
      SSD_OSC_FAST: begin
        if (ctl_prev_q != SSD_OSC_FAST) count_d = '0;
        else count_d = count_q + 1'b1;
      end
      SSD_OSC_SLOW: begin
        if (ctl_prev_q != SSD_OSC_SLOW) count_d = '0;
        else if (slow_rise) count_d = count_q + 1'b1;
      end
      SSD_OSC_STOP: count_d = count_q;
      default: count_d = count_q;
    endcase
  end

  always_ff @(posedge fast_osc_clk_in) begin
    if (!rst_n) begin
      count_q        <= '0;
      count_gray_out <= '0;
    end else begin
      count_q        <= count_d;
      count_gray_out <= count_d ^ (count_d >> 1);
    end
  end

endmodule

// >>> src/ssd_regs.sv
`timescale 1ns/1ps
`include "ssd_defs.svh"

// Overview of operation
// - Bit 15 shows synchronised alert pin level.
// - Alert drive not pulling low sets bit 14.
// - Serial-out drive/feedback mismatch sets bit 13.
// - Checksum failure sets sticky bit 12.
// - Wrong frame clock count sets bit 11.
// - Bits 10-8 report operating state.
// - Over-voltage in active/standby sets bit 5.
// - Under-voltage in active/standby sets bit 4.
// - Threshold crossings latch bits 3 to 0.
// - Bits 5-4 give read-only silicon revision.
// - Bit 2 disables frame checksum when set.
// - Bits 1-0 reset, start or stop counter.
// - Monitor returns cycles since counter start.
// - Sixteen-bit counter wraps at maximum value.
// - Alert cause shows any set flag.

module ssd_regs
  import ssd_pkg::*;
#(
  parameter int CNT_W        = 16,
  parameter int ALERT_SETTLE = `SSD_ALERT_SETTLE_CYC
) (
  input  wire logic                   mclk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   fast_osc_clk_in,
  input  wire logic                   slow_osc_in,
  input  wire logic                   reg_rd_en_in,
  input  wire logic                   reg_wr_en_in,
  input  wire logic [`SSD_ADDR_W-1:0] reg_addr_in,
  input  wire logic [15:0]            reg_wdata_in,
  input  wire logic                   alert_drive_in,
  input  wire logic                   alert_level_feedback_in,
  input  wire logic                   sdo_oe_in,
  input  wire logic                   sdo_drive_in,
  input  wire logic                   sdo_feedback_in,
  input  wire logic                   crc_fail_in,
  input  wire logic                   frame_len_fail_in,
  input  wire logic                   over_voltage_in,
  input  wire logic                   under_voltage_in,
  input  wire logic                   temp_cross_in,
  input  wire logic                   z_cross_in,
  input  wire logic                   y_cross_in,
  input  wire logic                   x_cross_in,
  input  wire logic [2:0]             operating_state_in,
  input  wire logic [1:0]             revision_strap_in,
  output logic      [15:0]            reg_rdata_out,
  output logic                        reg_rvalid_out,
  output logic                        checksum_off_out,
  output logic                        alert_cause_sys_out
);

  initial begin
    if (CNT_W != 16) $error("CNT_W must be 16 to fit the monitor register");
    if (ALERT_SETTLE < 1) $error("ALERT_SETTLE must be at least 1");
  end

  localparam int SW = $clog2(ALERT_SETTLE + 1);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic hit(input logic [`SSD_ADDR_W-1:0] a,
                               input logic [`SSD_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic supply_watched(input logic [2:0] st);
    case (ssd_opstate_t'(st))
      SSD_ST_STANDBY,
      SSD_ST_ACTIVE_CONT,
      SSD_ST_ACTIVE_TRIG,
      SSD_ST_DUTY_ACTIVE: supply_watched = 1'b1;
      default:            supply_watched = 1'b0;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0]       alrt_sync_q;
  logic [1:0]       sdo_sync_q;
  logic [1:0]       ov_sync_q;
  logic [1:0]       uv_sync_q;
  logic [1:0]       sdo_oe_dly_q;
  logic [1:0]       sdo_val_dly_q;
  logic [SW-1:0]    settle_q;
  logic             strap_pend_q;
  logic [1:0]       revision_q;
  logic             checksum_off_q;
  ssd_osc_ctl_t     osc_ctl_q;
  logic [15:0]      flags_q;
  logic [15:0]      flags_d;
  logic [15:0]      events;
  logic             sys_rd;
  logic [CNT_W-1:0] osc_gray;
  logic [CNT_W-1:0] gray_s1_q;
  logic [CNT_W-1:0] gray_s2_q;
  logic [CNT_W-1:0] gray_s3_q;
  logic [CNT_W-1:0] oscillator_tally_q;
  logic [15:0]      sys_view;
  logic [15:0]      tc_view;
  logic [15:0]      rdata_d;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk_in) begin
    alrt_sync_q <= {alrt_sync_q[0], alert_level_feedback_in};
    sdo_sync_q  <= {sdo_sync_q[0], sdo_feedback_in};
    ov_sync_q   <= {ov_sync_q[0], over_voltage_in};
    uv_sync_q   <= {uv_sync_q[0], under_voltage_in};
  end

  // ****************************************
  // Serial-out drive check
  // ****************************************
  // Driven value is delayed to line up with the two-stage feedback path.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sdo_oe_dly_q  <= 2'h0;
      sdo_val_dly_q <= 2'h0;
    end else begin
      sdo_oe_dly_q  <= {sdo_oe_dly_q[0], sdo_oe_in};
      sdo_val_dly_q <= {sdo_val_dly_q[0], sdo_drive_in};
    end
  end

  // ****************************************
  // Alert drive check
  // ****************************************
  // The pin is given a settle time before a still-high level counts as a fault.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      settle_q <= '0;
    end else if (!alert_drive_in) begin
      settle_q <= '0;
    end else if (settle_q != SW'(ALERT_SETTLE)) begin
      settle_q <= settle_q + 1'b1;
    end
  end

  // ****************************************
  // Event collection
  // ****************************************
  always_comb begin
    events = 16'h0000;
    events[`SSD_SYS_ALERT_FAULT] = alert_drive_in && alrt_sync_q[1] &&
                                (settle_q == SW'(ALERT_SETTLE - 1));
    events[`SSD_SYS_SO_FAULT]    = sdo_oe_dly_q[1] && sdo_oe_dly_q[0] &&
                                (sdo_val_dly_q[1] != sdo_sync_q[1]);
    events[`SSD_SYS_CRC]      = crc_fail_in;
    events[`SSD_SYS_FRAME]    = frame_len_fail_in;
    events[`SSD_SYS_OV]       = ov_sync_q[1] &&
                                supply_watched(operating_state_in);
    events[`SSD_SYS_UV]       = uv_sync_q[1] &&
                                supply_watched(operating_state_in);
    events[`SSD_SYS_TEMP]     = temp_cross_in;
    events[`SSD_SYS_ZTH]      = z_cross_in;
    events[`SSD_SYS_YTH]      = y_cross_in;
    events[`SSD_SYS_XTH]      = x_cross_in;
  end

  // ****************************************
  // Sticky flags
  // ****************************************
  assign sys_rd = reg_rd_en_in && hit(reg_addr_in, `SSD_OFS_STATUS);

  always_comb begin
    flags_d = flags_q;
    if (sys_rd) flags_d = 16'h0000;
    flags_d = (flags_d | events) & `SSD_SYS_FLAG_MASK;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      flags_q <= `SSD_SYS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      alert_cause_sys_out <= 1'b0;
    end else begin
      alert_cause_sys_out <= |flags_d;
    end
  end

  // ****************************************
  // Revision strap
  // ****************************************
  // The strap is caught on the first edge after reset is released.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      strap_pend_q <= 1'b1;
      revision_q   <= 2'h0;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      revision_q   <= revision_strap_in;
    end
  end

  // ****************************************
  // Writable controls
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      checksum_off_q <= 1'b0;
      osc_ctl_q      <= SSD_OSC_RESET;
    end else if (reg_wr_en_in && hit(reg_addr_in, `SSD_OFS_TEST_CFG)) begin
      checksum_off_q <= reg_wdata_in[`SSD_TC_CKSUM];
      osc_ctl_q      <= ssd_osc_ctl_t'(
                          reg_wdata_in[`SSD_TC_OSC_HI:`SSD_TC_OSC_LO]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      checksum_off_out <= 1'b0;
    end else begin
      checksum_off_out <= checksum_off_q;
    end
  end

  // ****************************************
  // Oscillator counter
  // ****************************************
  ssd_osc_counter #(
    .CNT_W (CNT_W)
  ) u_osc_counter (
    .fast_osc_clk_in (fast_osc_clk_in),
    .nrst_in         (nrst_in),
    .ctl_in          (osc_ctl_q),
    .slow_osc_in     (slow_osc_in),
    .count_gray_out  (osc_gray)
  );

  always_ff @(posedge mclk_in) begin
    gray_s1_q <= osc_gray;
    gray_s2_q <= gray_s1_q;
    gray_s3_q <= gray_s2_q;
  end

  // A value is taken only when two samples agree, which hides a multi-bit reset step.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      oscillator_tally_q <= `SSD_OSC_MON_RESET;
    end else if (gray_s2_q == gray_s3_q) begin
      oscillator_tally_q <= gray2bin(gray_s3_q);
    end
  end

  // ****************************************
  // Read views
  // ****************************************
  always_comb begin
    sys_view = flags_q;
    sys_view[`SSD_SYS_ALERT_LEVEL] = alrt_sync_q[1];
    sys_view[`SSD_SYS_OPST_HI:`SSD_SYS_OPST_LO] = operating_state_in;
  end

  always_comb begin
    tc_view = 16'h0000;
    tc_view[`SSD_TC_RSVD_HI:`SSD_TC_RSVD_LO] = `SSD_TC_RSVD_VAL;
    tc_view[`SSD_TC_REV_HI:`SSD_TC_REV_LO]   = revision_q;
    tc_view[`SSD_TC_CKSUM]                   = checksum_off_q;
    tc_view[`SSD_TC_OSC_HI:`SSD_TC_OSC_LO]   = osc_ctl_q;
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (hit(reg_addr_in, `SSD_OFS_STATUS)) rdata_d = sys_view;
    else if (hit(reg_addr_in, `SSD_OFS_TEST_CFG)) rdata_d = tc_view;
    else if (hit(reg_addr_in, `SSD_OFS_OSC_MON)) rdata_d = oscillator_tally_q;
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      reg_rdata_out  <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_en_in;
      if (reg_rd_en_in) reg_rdata_out <= rdata_d;
    end
  end

endmodule

// >>> tb/ssd_regs_asserts.sv
`timescale 1ns/1ps
`include "ssd_defs.svh"
// ****************
// Register port checks
// ****************
module ssd_regs_asserts (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        reg_rd_en_in,
  input wire logic        reg_wr_en_in,
  input wire logic [5:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        crc_fail_in,
  input wire logic        frame_len_fail_in,
  input wire logic        temp_cross_in,
  input wire logic        z_cross_in,
  input wire logic        y_cross_in,
  input wire logic        x_cross_in,
  input wire logic [2:0]  operating_state_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        checksum_off_out,
  input wire logic        alert_cause_sys_out
);
  logic rd_sys;
  logic evt;
  assign rd_sys = reg_rd_en_in && reg_addr_in == `SSD_OFS_STATUS;
  assign evt = crc_fail_in | frame_len_fail_in | temp_cross_in | z_cross_in | y_cross_in
    | x_cross_in;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  AST_EVT_CAUSE: assert property (evt |=> alert_cause_sys_out)
    else $error("event left alert cause low");
  AST_CRC_READ: assert property (
    crc_fail_in ##1 !reg_rd_en_in ##1 rd_sys |=> reg_rvalid_out && reg_rdata_out[12])
    else $error("checksum flag not returned");
  AST_FRAME_READ: assert property (
    frame_len_fail_in ##1 !reg_rd_en_in ##1 rd_sys |=> reg_rdata_out[11])
    else $error("frame flag not returned");
  AST_CLEAR: assert property (
    rd_sys && !evt ##1 !evt && !reg_rd_en_in ##1 rd_sys
    |=> reg_rdata_out[12:11] == 2'h0 && reg_rdata_out[3:0] == 4'h0)
    else $error("flag survived its clearing read");
  AST_OPSTATE: assert property (
    rd_sys |=> reg_rdata_out[10:8] == $past(operating_state_in))
    else $error("operating state field wrong");
  AST_SYS_RSVD: assert property (rd_sys |=> reg_rdata_out[7:6] == 2'h0)
    else $error("reserved status bits not zero");
  AST_TC_FIXED: assert property (
    reg_rd_en_in && reg_addr_in == `SSD_OFS_TEST_CFG
    |=> reg_rdata_out[15:6] == 10'h001 && !reg_rdata_out[3])
    else $error("fixed config bits wrong");
  AST_CKSUM: assert property (
    reg_wr_en_in && reg_addr_in == `SSD_OFS_TEST_CFG ##1 !reg_wr_en_in
    |=> checksum_off_out == $past(reg_wdata_in[2], 2))
    else $error("checksum control not applied");
endmodule

bind ssd_regs ssd_regs_asserts u_chk (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_rd_en_in(reg_rd_en_in),
  .reg_wr_en_in(reg_wr_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .crc_fail_in(crc_fail_in), .frame_len_fail_in(frame_len_fail_in),
  .temp_cross_in(temp_cross_in), .z_cross_in(z_cross_in), .y_cross_in(y_cross_in),
  .x_cross_in(x_cross_in), .operating_state_in(operating_state_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .checksum_off_out(checksum_off_out), .alert_cause_sys_out(alert_cause_sys_out));

// >>> tb/ssd_host_model.sv
`timescale 1ns/1ps
// ****************
// Host register access
// ****************
module ssd_host_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in,
  output logic             reg_rd_en_out,
  output logic             reg_wr_en_out,
  output logic      [5:0]  reg_addr_out,
  output logic      [15:0] reg_wdata_out
);
  initial begin
    reg_rd_en_out = 1'b0;
    reg_wr_en_out = 1'b0;
    reg_addr_out = 6'h3F;
    reg_wdata_out = 16'hFFFF;
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(negedge mclk_in);
    reg_wr_en_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = v;
    @(negedge mclk_in);
    reg_wr_en_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] v, output logic ok);
    int n;
    @(negedge mclk_in);
    reg_rd_en_out = 1'b1;
    reg_addr_out = a;
    @(negedge mclk_in);
    reg_rd_en_out = 1'b0;
    reg_addr_out = ~a;
    ok = 1'b0;
    v = 16'h0000;
    // The answer stands only from the read edge to the next one, so it is taken here.
    for (n = 0; n < 4 && !ok; n++) begin
      ok = (reg_rvalid_in === 1'b1);
      v = reg_rdata_in;
      if (!ok) @(negedge mclk_in);
    end
  endtask
endmodule

// >>> tb/test_ssd_regs.sv
`timescale 1ns/1ps
`include "ssd_defs.svh"
// ****************
// Bench top
// ****************
module test_ssd_regs
  import ssd_pkg::*;
;
  localparam int AS = `SSD_ALERT_SETTLE_CYC;
  logic        mclk_in, nrst_in, fast_osc_clk_in, slow_osc_in, alert_drive_in, alert_fb;
  logic        sdo_oe, sdo_val, sdo_fb, rd_en, wr_en, rvalid, ck_off, cause;
  logic [5:0]  addr, ev;
  logic [1:0]  sup, strap;
  logic [2:0]  st;
  logic [15:0] wdata, rdata, d, d2, w;
  logic [31:0] rng = 32'h00014A01;
  int          err_total, checks_done, i, k;

  ssd_regs uut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .fast_osc_clk_in(fast_osc_clk_in),
    .slow_osc_in(slow_osc_in), .reg_rd_en_in(rd_en), .reg_wr_en_in(wr_en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .alert_drive_in(alert_drive_in),
    .alert_level_feedback_in(alert_fb), .sdo_oe_in(sdo_oe), .sdo_drive_in(sdo_val),
    .sdo_feedback_in(sdo_fb), .crc_fail_in(ev[5]), .frame_len_fail_in(ev[4]),
    .over_voltage_in(sup[1]), .under_voltage_in(sup[0]), .temp_cross_in(ev[3]),
    .z_cross_in(ev[2]), .y_cross_in(ev[1]), .x_cross_in(ev[0]),
    .operating_state_in(st), .revision_strap_in(strap), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .checksum_off_out(ck_off), .alert_cause_sys_out(cause));
  ssd_host_model host (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_rd_en_out(rd_en), .reg_wr_en_out(wr_en), .reg_addr_out(addr), .reg_wdata_out(wdata));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [15:0] exp_sys(input logic fb, input logic [2:0] s,
                                          input logic [15:0] f);
    return (f & `SSD_SYS_FLAG_MASK) | {fb, 4'h0, s, 8'h00};
  endfunction
  function automatic logic [15:0] exp_tc(input logic [1:0] rv, input logic c,
                                         input logic [1:0] ctl);
    return {10'h001, rv, 1'b0, c, ctl};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdr(input logic [5:0] a, output logic [15:0] v);
    logic ok;
    host.rd(a, v, ok);
    if (ok !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  // The oscillator runs free at its own phase.
  initial begin
    fast_osc_clk_in = 1'b0;
    #1.3;
    forever #3 fast_osc_clk_in = ~fast_osc_clk_in;
  end

  initial begin
    {nrst_in, slow_osc_in, alert_drive_in, sdo_oe, sdo_val, ev, sup} = '0;
    {alert_fb, sdo_fb} = 2'h3;
    st = SSD_ST_STANDBY;
    err_total = 0;
    checks_done = 0;
    strap = 2'(xs() & 32'h1);
    cyc(12);
    nrst_in = 1'b1;
    cyc(2);
    rdr(6'h0E, d);
    chk("sys_rst", d, exp_sys(1'b1, st, 16'h0000));
    rdr(6'h0F, d);
    chk("tc_rst", d, exp_tc(strap, 1'b0, 2'h0));
    rdr(6'h10, d);
    chk("osc_rst", d, 16'h0000);
    rdr(6'h05, d);
    chk("unmapped", d, 16'h0000);
    for (i = 0; i < 6; i++) begin
      st = 3'(xs() % 7);
      ev = 6'h01 << i;
      cyc(1);
      ev = 6'h00;
      chk("cause_set", {15'h0, cause}, 16'h0001);
      rdr(6'h0E, d);
      chk("flag", d, exp_sys(1'b1, st, 16'h0001 << (i > 3 ? i + 7 : i)));
      rdr(6'h0E, d);
      chk("cleared", d, exp_sys(1'b1, st, 16'h0000));
      chk("cause_clr", {15'h0, cause}, 16'h0000);
    end
    fork
      rdr(6'h0E, d);
      begin
        cyc(1);
        ev = 6'h20;
        cyc(1);
        ev = 6'h00;
      end
    join
    chk("same_cyc", d, exp_sys(1'b1, st, 16'h0000));
    rdr(6'h0E, d);
    chk("kept", d, exp_sys(1'b1, st, 16'h1000));
    for (i = 0; i < 7; i++) begin
      st = 3'(i);
      w = 16'(xs() % 3 + 1);
      sup = w[1:0];
      cyc(4);
      sup = 2'h0;
      cyc(4);
      rdr(6'h0E, d);
      chk("supply", d, exp_sys(1'b1, st, (i > 0 && i < 5) ? w << 4 : 16'h0000));
    end
    for (i = 0; i < 2; i++) begin
      alert_fb = i[0];
      alert_drive_in = 1'b1;
      cyc(AS + 4);
      rdr(6'h0E, d);
      chk("alert", d, exp_sys(i[0], st, {1'b0, i[0], 14'h0}));
      alert_drive_in = 1'b0;
      alert_fb = 1'b1;
      cyc(1);
    end
    for (i = 0; i < 2; i++) begin
      w = 16'(xs());
      sdo_val = w[0];
      sdo_fb = w[0] ^ i[0];
      sdo_oe = 1'b1;
      cyc(6);
      sdo_oe = 1'b0;
      cyc(4);
      sdo_fb = ~sdo_fb;
      rdr(6'h0E, d);
      chk("sdo", d, exp_sys(1'b1, st, {2'h0, i[0], 13'h0}));
    end
    for (i = 0; i < 2; i++) begin
      w = 16'(xs());
      w[2] = ~i[0];
      w[1:0] = 2'h0;
      host.wr(6'h0F, w);
      cyc(2);
      chk("cksum", {15'h0, ck_off}, {15'h0, w[2]});
      rdr(6'h0F, d);
      chk("tcfg", d, exp_tc(strap, w[2], 2'h0));
    end
    host.wr(6'h0E, 16'hFFFF);
    host.wr(6'h10, 16'hFFFF);
    rdr(6'h0E, d);
    chk("sys_ro", d, exp_sys(1'b1, st, 16'h0000));
    host.wr(6'h0F, 16'(SSD_OSC_FAST));
    cyc(300);
    host.wr(6'h0F, 16'(SSD_OSC_STOP));
    cyc(20);
    rdr(6'h10, d);
    rdr(6'h10, d2);
    chk("osc_hold", d2, d);
    chk("osc_fast", {15'h0, d > 16'h0188 && d < 16'h019C}, 16'h0001);
    // Long enough for the fast count to pass the 16-bit limit and come round again.
    host.wr(6'h0F, 16'(SSD_OSC_FAST));
    cyc(49200);
    host.wr(6'h0F, 16'(SSD_OSC_STOP));
    cyc(20);
    rdr(6'h10, d);
    chk("osc_wrap", {15'h0, d > 16'h0038 && d < 16'h004C}, 16'h0001);
    host.wr(6'h0F, 16'(SSD_OSC_RESET));
    cyc(20);
    rdr(6'h10, d);
    chk("osc_zero", d, 16'h0000);
    host.wr(6'h0F, 16'(SSD_OSC_SLOW));
    cyc(10);
    k = xs() % 5 + 3;
    repeat (k) begin
      slow_osc_in = 1'b1;
      cyc(5);
      slow_osc_in = 1'b0;
      cyc(5);
    end
    cyc(10);
    rdr(6'h10, d);
    chk("osc_slow", d, 16'(k));
    wrap_up();
  end
endmodule
